// ### logic/psp_pkg.sv
package psp_pkg;

  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFF_DATA_PORT   = 8'h04;
  localparam logic [7:0] OFF_CTRL_DIR    = 8'h08;
  localparam logic [7:0] OFF_IRQ_FLAGS   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ENABLES = 8'h10;
  localparam logic [7:0] OFF_IRQ_PRIOS   = 8'h14;
  localparam logic [7:0] OFF_DATA_DIR    = 8'h18;
  localparam logic [7:0] OFF_CTRL_LATCH  = 8'h1C;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int BIT_IN_FULL   = 7;
  localparam int BIT_OUT_FULL  = 6;
  localparam int BIT_OVERRUN   = 5;
  localparam int BIT_PORT_EN   = 4;
  localparam int BIT_PORT_IRQ  = 7;
  localparam int PIN_RD        = 0;
  localparam int PIN_WR        = 1;
  localparam int PIN_CS        = 2;
  localparam int SYNC_WIDTH    = 12;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [7:0] RST_DATA_LATCH = 8'h00;
  localparam logic [7:0] RST_CTRL_DIR   = 8'hFF;
  localparam logic [7:0] RST_DATA_DIR   = 8'hFF;
  localparam logic [7:0] RST_IRQ_PRIOS  = 8'hFF;
  localparam logic [2:0] RST_CTRL_LATCH = 3'h0;

  // --------------------------------------------------------------
  // transfer states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } psp_state_t;

endpackage

// ### logic/psp_port.sv
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module psp_port #(
  parameter bit EIGHTY_PIN = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  input  wire logic [7:0]  dataIn,
  output logic      [7:0]  dataOut,
  output logic      [7:0]  dataOe,
  input  wire logic [2:0]  ctrlIn,
  output logic      [2:0]  ctrlOut,
  output logic      [2:0]  ctrlOe,
  input  wire logic        extMemMode
);

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic [psp_pkg::SYNC_WIDTH-1:0] syncRaw;
  logic [psp_pkg::SYNC_WIDTH-1:0] sync1_q;
  logic [psp_pkg::SYNC_WIDTH-1:0] sync2_q;
  logic [7:0]          dataS;
  logic                rdS;
  logic                wrS;
  logic                csS;
  logic                extS;
  psp_pkg::psp_state_t state_q;
  psp_pkg::psp_state_t state_d;
  logic                mode_q;
  logic                pspEn;
  logic                inFull_q;
  logic                outFull_q;
  logic                overrun_q;
  logic                portIrq_q;
  logic                portIrqEn_q;
  logic [7:0]          prio_q;
  logic [7:0]          latch_q;
  logic [7:0]          inBuf_q;
  logic [7:0]          ctrlDir_q;
  logic [7:0]          dataDir_q;
  logic [2:0]          ctrlLat_q;
  logic                ack_q;
  logic [31:0]         dat_q;
  logic [31:0]         rdMux;
  logic                irq_q;
  logic [7:0]          dataOut_q;
  logic [7:0]          dataOe_q;
  logic [2:0]          ctrlOut_q;
  logic [2:0]          ctrlOe_q;
  logic                wbReq;
  logic                wbDo;
  logic                wbWr;
  logic                cpuDataWr;
  logic                cpuDataRd;
  logic                wrEnd;
  logic                rdStart;
  logic                rdEnd;

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  assign syncRaw = {extMemMode, ctrlIn, dataIn};

  // the first stage feeds only the second; all logic reads stage two
  genvar gi;
  generate
    for (gi = 0; gi < psp_pkg::SYNC_WIDTH; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else if (ce) begin
          sync1_q[gi] <= syncRaw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign dataS = sync2_q[7:0];
  assign rdS   = sync2_q[8 + psp_pkg::PIN_RD];
  assign wrS   = sync2_q[8 + psp_pkg::PIN_WR];
  assign csS   = sync2_q[8 + psp_pkg::PIN_CS];
  assign extS  = sync2_q[11];

  // only in internal-memory configuration on the large package
  assign pspEn = mode_q & (~EIGHTY_PIN | ~extS);

  // --------------------------------------------------------------
  // wishbone slave
  // --------------------------------------------------------------
  // one wait state: data latched as ack rises, write done while ack high
  assign wbReq     = wb_cyc_i & wb_stb_i;
  assign wbDo      = wbReq & ack_q;
  assign wbWr      = wbDo & wb_we_i & wb_sel_i[0];
  assign cpuDataWr = wbWr & (wb_adr_i == psp_pkg::OFF_DATA_PORT);
  assign cpuDataRd = wbDo & ~wb_we_i & pspEn &
                     (wb_adr_i == psp_pkg::OFF_DATA_PORT);

  always_comb begin
    rdMux = 32'h0000_0000;
    case (wb_adr_i)
      psp_pkg::OFF_CTRL_STATUS: begin
        rdMux[psp_pkg::BIT_IN_FULL]  = inFull_q;
        rdMux[psp_pkg::BIT_OUT_FULL] = outFull_q;
        rdMux[psp_pkg::BIT_OVERRUN]  = overrun_q;
        rdMux[psp_pkg::BIT_PORT_EN]  = mode_q;
      end
      psp_pkg::OFF_DATA_PORT: begin
        rdMux[7:0] = pspEn ? inBuf_q : dataS;
      end
      psp_pkg::OFF_CTRL_DIR: begin
        rdMux[7:0] = ctrlDir_q;
      end
      psp_pkg::OFF_IRQ_FLAGS: begin
        rdMux[psp_pkg::BIT_PORT_IRQ] = portIrq_q;
      end
      psp_pkg::OFF_IRQ_ENABLES: begin
        rdMux[psp_pkg::BIT_PORT_IRQ] = portIrqEn_q;
      end
      psp_pkg::OFF_IRQ_PRIOS: begin
        rdMux[7:0] = prio_q;
      end
      psp_pkg::OFF_DATA_DIR: begin
        rdMux[7:0] = dataDir_q;
      end
      psp_pkg::OFF_CTRL_LATCH: begin
        rdMux[2:0] = ctrlLat_q;
        rdMux[6:4] = {csS, wrS, rdS};
      end
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= wbReq & ~ack_q;
      if (wbReq & ~ack_q) begin
        dat_q <= rdMux;
      end
    end
  end

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_q    <= 1'b0;
      portIrqEn_q <= 1'b0;
      prio_q    <= psp_pkg::RST_IRQ_PRIOS;
      ctrlDir_q <= psp_pkg::RST_CTRL_DIR;
      dataDir_q <= psp_pkg::RST_DATA_DIR;
      ctrlLat_q <= psp_pkg::RST_CTRL_LATCH;
    end else if (ce && wbWr) begin
      case (wb_adr_i)
        psp_pkg::OFF_CTRL_STATUS: begin
          mode_q <= wb_dat_i[psp_pkg::BIT_PORT_EN];
        end
        psp_pkg::OFF_CTRL_DIR: begin
          ctrlDir_q <= wb_dat_i[7:0];
        end
        psp_pkg::OFF_IRQ_ENABLES: begin
          portIrqEn_q <= wb_dat_i[psp_pkg::BIT_PORT_IRQ];
        end
        psp_pkg::OFF_IRQ_PRIOS: begin
          prio_q <= wb_dat_i[7:0];
        end
        psp_pkg::OFF_DATA_DIR: begin
          dataDir_q <= wb_dat_i[7:0];
        end
        psp_pkg::OFF_CTRL_LATCH: begin
          ctrlLat_q <= wb_dat_i[2:0];
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------
  // transfer state machine
  // --------------------------------------------------------------
  // write wins if both strobes fall together; disabling aborts quietly
  always_comb begin
    state_d = state_q;
    case (state_q)
      psp_pkg::ST_IDLE: begin
        if (pspEn && !csS && !wrS) begin
          state_d = psp_pkg::ST_WRITE;
        end else if (pspEn && !csS && !rdS) begin
          state_d = psp_pkg::ST_READ;
        end
      end
      psp_pkg::ST_WRITE: begin
        if (!pspEn || csS || wrS) begin
          state_d = psp_pkg::ST_IDLE;
        end
      end
      psp_pkg::ST_READ: begin
        if (!pspEn || csS || rdS) begin
          state_d = psp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = psp_pkg::ST_IDLE;
      end
    endcase
  end

  assign wrEnd   = (state_q == psp_pkg::ST_WRITE) & pspEn & (csS | wrS);
  assign rdStart = (state_q == psp_pkg::ST_IDLE) & (state_d == psp_pkg::ST_READ);
  assign rdEnd   = (state_q == psp_pkg::ST_READ) & pspEn & (csS | rdS);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= psp_pkg::ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------
  // data latch and input buffer
  // --------------------------------------------------------------
  // data is taken at the end of the strobe, so it must hold past it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      latch_q <= psp_pkg::RST_DATA_LATCH;
      inBuf_q <= psp_pkg::RST_DATA_LATCH;
    end else if (ce) begin
      if (cpuDataWr) begin
        latch_q <= wb_dat_i[7:0];
      end
      if (wrEnd) begin
        inBuf_q <= dataS;
      end
    end
  end

  // --------------------------------------------------------------
  // status flags and interrupt
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      inFull_q <= 1'b0;
    end else if (ce) begin
      if (wrEnd) begin
        inFull_q <= 1'b1;
      end else if (cpuDataRd) begin
        inFull_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      overrun_q <= 1'b0;
    end else if (ce) begin
      if (wrEnd && inFull_q && !cpuDataRd) begin
        overrun_q <= 1'b1;
      end else if (wbWr && wb_adr_i == psp_pkg::OFF_CTRL_STATUS) begin
        overrun_q <= overrun_q & wb_dat_i[psp_pkg::BIT_OVERRUN];
      end
    end
  end

  // a cpu write during an active read goes straight out, flag stays low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      outFull_q <= 1'b0;
    end else if (ce) begin
      if (cpuDataWr && state_q != psp_pkg::ST_READ) begin
        outFull_q <= 1'b1;
      end else if (rdStart) begin
        outFull_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      portIrq_q <= 1'b0;
    end else if (ce) begin
      if (wrEnd || rdEnd) begin
        portIrq_q <= 1'b1;
      end else if (wbWr && wb_adr_i == psp_pkg::OFF_IRQ_FLAGS &&
                   wb_dat_i[psp_pkg::BIT_PORT_IRQ]) begin
        portIrq_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= portIrq_q & portIrqEn_q;
    end
  end

  // --------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dataOut_q <= psp_pkg::RST_DATA_LATCH;
      dataOe_q  <= 8'h00;
      ctrlOut_q <= psp_pkg::RST_CTRL_LATCH;
      ctrlOe_q  <= 3'h0;
    end else if (ce) begin
      dataOut_q <= cpuDataWr ? wb_dat_i[7:0] : latch_q;
      ctrlOut_q <= ctrlLat_q;
      if (pspEn) begin
        dataOe_q <= (state_d == psp_pkg::ST_READ) ? 8'hFF : 8'h00;
        ctrlOe_q <= 3'h0;
      end else begin
        dataOe_q <= ~dataDir_q;
        ctrlOe_q <= ~ctrlDir_q[2:0];
      end
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign irq      = irq_q;
  assign dataOut  = dataOut_q;
  assign dataOe   = dataOe_q;
  assign ctrlOut  = ctrlOut_q;
  assign ctrlOe   = ctrlOe_q;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset || !ce);

  sequence sWrEnd;
    wrEnd ##1 (inFull_q && portIrq_q);
  endsequence
  sequence sRdRelease;
    rdEnd ##1 (dataOe_q == 8'h00 && portIrq_q);
  endsequence

  a_write_end_flags: assert property (wrEnd |-> sWrEnd)
    else $error("write end did not set input full and irq flag");
  a_read_release: assert property (rdEnd |-> sRdRelease)
    else $error("read end did not release pins and set irq flag");
  a_read_drive: assert property (rdStart && !cpuDataWr |=>
      dataOe_q == 8'hFF && dataOut_q == $past(latch_q))
    else $error("read start did not drive latch onto pins");
  a_out_full_clear: assert property (rdStart && !cpuDataWr |=> !outFull_q)
    else $error("output full not cleared by external read");
  a_overrun_set: assert property (wrEnd && inFull_q && !cpuDataRd |=> overrun_q)
    else $error("overrun not flagged on write while full");
  a_ctrl_low_zero: assert property (
      ack_q && !wb_we_i && wb_adr_i == psp_pkg::OFF_CTRL_STATUS |->
      dat_q[3:0] == 4'h0)
    else $error("control low bits not zero");
  a_gpio_mode: assert property (!pspEn |=> dataOe_q == ~$past(dataDir_q))
    else $error("disabled port does not follow direction");
  a_write_span: assert property (
      pspEn && state_q == psp_pkg::ST_IDLE && !csS && !wrS |=> state_q == psp_pkg::ST_WRITE)
    else $error("write did not begin with select and write strobe low");
  a_ctrl_inputs: assert property (pspEn |=> ctrlOe_q == 3'h0)
    else $error("control pins driven in slave port mode");

endmodule // psp_port

// ### verif/psp_host_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// external processor on the strobe side
// --------------------------------------------------------------
module psp_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pinLevel,
  output logic      [2:0] ctrlDrv,
  output logic      [7:0] dataDrv
);
  // ctrlDrv is {select_n, write_n, read_n}; idle all high
  initial begin
    ctrlDrv = 3'h7;
    dataDrv = 8'h00;
  end

  // strobes held 6 cycles, above the 2-cycle sync window
  task automatic extWrite(input logic [7:0] b);
    @(posedge sys_clk);
    ctrlDrv <= 3'h1;
    dataDrv <= b;
    repeat (6) @(posedge sys_clk);
    ctrlDrv <= 3'h7;
    repeat (6) @(posedge sys_clk);
    // released bus shows the inverse so a stale value cannot pass
    dataDrv <= ~b;
  endtask

  task automatic extRead(output logic [7:0] b);
    @(posedge sys_clk);
    ctrlDrv <= 3'h2;
    repeat (6) @(posedge sys_clk);
    b = pinLevel;
    ctrlDrv <= 3'h7;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule // psp_host_model

// ### verif/parallel_slave_port_test.sv
`timescale 1ns/1ps
module parallel_slave_port_test;
  logic        sys_clk, reset, ce, extMemMode, irq, wb_ack_o;
  logic        wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i, dataOut, dataOe, hostData, dataPins, b, got;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [2:0]  ctrlOut, ctrlOe, hostCtrl, ctrlPins;
  logic [31:0] expQ[$];
  string       nameQ[$];
  int          miscompares = 0;
  int          compares = 0;
  int          seed = 77;

  assign dataPins = (dataOe & dataOut) | (~dataOe & hostData);
  assign ctrlPins = (ctrlOe & ctrlOut) | (~ctrlOe & hostCtrl);

  psp_port dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .dataIn(dataPins), .dataOut(dataOut), .dataOe(dataOe), .ctrlIn(ctrlPins),
    .ctrlOut(ctrlOut), .ctrlOe(ctrlOe), .extMemMode(extMemMode));

  psp_host_model host (.sys_clk(sys_clk), .pinLevel(dataPins), .ctrlDrv(hostCtrl),
    .dataDrv(hostData));

  // --------------------------------------------------------------
  // clock, checks, closing
  // --------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // read data is taken at the edge that samples ack high
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && wb_cyc_i === 1'b1)
      chk(nameQ.pop_front(), expQ.pop_front(), wb_dat_o);
  end

  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wrReg(input logic [7:0] adr, input logic [31:0] dat);
    wbXfer(1'b1, adr, dat);
  endtask

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] e, input string n);
    expQ.push_back(e);
    nameQ.push_back(n);
    wbXfer(1'b0, adr, 32'h0);
  endtask

  task automatic irqChk(input logic e);
    repeat (2) @(posedge sys_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    reset = 1'b1; ce = 1'b1; extMemMode = 1'b0;
    wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 8'h00; wb_sel_i = 4'hF; wb_dat_i = 32'h0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'h00, "status");
    rdChk(psp_pkg::OFF_CTRL_DIR, 32'hFF, "ctrlDir");
    rdChk(psp_pkg::OFF_IRQ_PRIOS, 32'hFF, "prios");
    rdChk(psp_pkg::OFF_DATA_DIR, 32'hFF, "dataDir");
    rdChk(8'h20, 32'h00, "unmapped");
    wrReg(psp_pkg::OFF_CTRL_DIR, 32'hFF);
    wrReg(psp_pkg::OFF_IRQ_ENABLES, 32'h80);
    // ones in the unimplemented bits must not stick
    wrReg(psp_pkg::OFF_CTRL_STATUS, 32'h1F);
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'h10, "status");
    b = 8'($random(seed));
    host.extWrite(b);
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'h90, "status");
    irqChk(1'b1);
    rdChk(psp_pkg::OFF_IRQ_FLAGS, 32'h80, "flags");
    b = 8'($random(seed));
    host.extWrite(b);
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'hB0, "status");
    rdChk(psp_pkg::OFF_DATA_PORT, {24'h0, b}, "inData");
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'h30, "status");
    wrReg(psp_pkg::OFF_CTRL_STATUS, 32'h10);
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'h10, "status");
    wrReg(psp_pkg::OFF_IRQ_FLAGS, 32'h80);
    irqChk(1'b0);
    b = 8'($random(seed));
    wrReg(psp_pkg::OFF_DATA_PORT, {24'h0, b});
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'h50, "status");
    host.extRead(got);
    chk("hostRead", {24'h0, b}, {24'h0, got});
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'h10, "status");
    irqChk(1'b1);
    chk("dataOe", 32'h0, {24'h0, dataOe});
    wrReg(psp_pkg::OFF_IRQ_FLAGS, 32'h80);
    // external-memory configuration must block the strobes
    extMemMode <= 1'b1;
    host.extWrite(8'h5A);
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'h10, "status");
    extMemMode <= 1'b0;
    wrReg(psp_pkg::OFF_CTRL_STATUS, 32'h00);
    wrReg(psp_pkg::OFF_DATA_DIR, 32'h00);
    // the latch write sets output full in either mode
    wrReg(psp_pkg::OFF_DATA_PORT, 32'h3C);
    repeat (2) @(posedge sys_clk);
    chk("dataOe", 32'hFF, {24'h0, dataOe});
    chk("dataOut", 32'h3C, {24'h0, dataOut});
    host.extWrite(8'hC3);
    rdChk(psp_pkg::OFF_CTRL_STATUS, 32'h40, "status");
    irqChk(1'b0);
    // control pins as outputs loop back through the synchronisers
    wrReg(psp_pkg::OFF_CTRL_LATCH, 32'h05);
    wrReg(psp_pkg::OFF_CTRL_DIR, 32'hF8);
    repeat (4) @(posedge sys_clk);
    chk("ctrlOe", 32'h7, {29'h0, ctrlOe});
    chk("ctrlOut", 32'h5, {29'h0, ctrlOut});
    rdChk(psp_pkg::OFF_CTRL_LATCH, 32'h55, "ctrlLatch");
    stop_test();
  end
endmodule // parallel_slave_port_test
